// ### core/frio_pkg.sv
// Package for the remote-I/O handshake block: bit positions, reset values,
// register map of the APB slave and command classes.
// Assumes a single clock domain; used by the top module, the checker and the bench.
package frio_pkg;

  // ----------------------------------------------------------------
  // Control word bit positions (master to device)
  // ----------------------------------------------------------------
  localparam int CTL_MON_LSB = 0;
  localparam int MON_CH = 6;
  localparam int CTL_ALM_CLR = 7;
  localparam int CTL_EXEC = 12;

  // ----------------------------------------------------------------
  // Status word bit positions (device to master)
  // ----------------------------------------------------------------
  localparam int STS_WARN = 6;
  localparam int STS_ALARM = 7;
  localparam int STS_LINK = 8;
  localparam int STS_DONE = 12;
  localparam int STS_REG_ERR = 13;
  localparam int STS_BUSY = 14;
  localparam logic [15:0] STS_RST = 16'h0000;

  // ----------------------------------------------------------------
  // APB register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_MON_FAIL = 8'h10;
  localparam logic [7:0] OFS_IRQ_STS = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;

  // CMD register: class in [1:0]
  localparam int CMD_CLASS_LSB = 0;
  // RESULT register write: bit0 finish, bit1 error
  localparam int RES_FINISH = 0;
  localparam int RES_ERROR = 1;
  // CTRL register: bit0 alarm trip pulse, bit1 warning level, bit2 link ok
  localparam int CTRL_TRIP = 0;
  localparam int CTRL_WARN = 1;
  localparam int CTRL_LINK = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Interrupt events
  localparam int IRQ_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ERR = 1;
  localparam int EV_ALARM = 2;
  localparam int EV_LAUNCH = 3;
  localparam logic [3:0] IRQ_RST = 4'h0;

  typedef enum logic [1:0] {
    CMD_PARAM,
    CMD_MAINT,
    CMD_OPER,
    CMD_RSVD
  } frio_cmd_class_t;

endpackage

// ### core/frio_edge.sv
// Request sampler: registers the request word each clock and reports
// rising and falling edges against the previous sample.
// Assumes the request word is synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module frio_edge #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] req_in,
  output logic [W-1:0] req_ff,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_ff <= '0;
      prev_ff <= '0;
    end
    else
    begin
      req_ff <= req_in;
      prev_ff <= req_ff;
    end
  end

  assign rise = req_ff & ~prev_ff;
  assign fall = ~req_ff & prev_ff;
endmodule
`default_nettype wire

// ### core/frio_top.sv
// Remote-I/O handshake of the converter's own control and status word,
// with an APB slave through which local firmware runs the command engine.
// Assumes master_to_device_bits is synchronous to pclk.
// What this block does
// - Control bits 0-5 request monitors 0-5; status bits 0-5 show them active.
// - A command launches only on the rising edge of execute request.
// - Execute request covers parameter, maintenance and operation commands.
// - A protective trip sets the alarm bit, held until the alarm clear request falls.
// - Falling alarm clear request while alarmed clears the alarm bit, unless a trip lands in the same cycle.
// - Done at status bit C, register error at D, busy at E.
// - Link health at status bit 8, warning at bit 6, others zero.
// - Success sets done, cleared when execute drops; errors raise register error.
// - Register error clears when the offending request goes low.
// - Busy high while parameter or maintenance command is processed.
// - Monitor active only while requested and processing correctly.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module frio_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] master_to_device_bits,
  output logic [15:0] device_to_master_bits,
  output logic cmd_launch,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import frio_pkg::*;

  // ----------------------------------------------------------------
  // Request sampling
  // ----------------------------------------------------------------
  logic [15:0] req_s;
  logic [15:0] req_rise;
  logic [15:0] req_fall;

  frio_edge #(.W(16)) u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .req_in(master_to_device_bits),
    .req_ff(req_s),
    .rise(req_rise),
    .fall(req_fall)
  );

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // APB access decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign mapped = reg_hit(paddr, OFS_CTRL) | reg_hit(paddr, OFS_STATUS) |
                  reg_hit(paddr, OFS_CMD) | reg_hit(paddr, OFS_RESULT) |
                  reg_hit(paddr, OFS_MON_FAIL) | reg_hit(paddr, OFS_IRQ_STS) |
                  reg_hit(paddr, OFS_IRQ_EN) | reg_hit(paddr, OFS_IRQ_CLR);

  logic [2:0] ctrl_ff;
  logic [1:0] cmd_class_ff;
  logic [MON_CH-1:0] mon_fail_ff;
  logic [IRQ_W-1:0] irq_sts_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic trip;
  logic res_finish;
  logic res_error;

  // Trip is a write-one pulse so a standing bit cannot re-arm the alarm
  assign trip = wr & reg_hit(paddr, OFS_CTRL) & pwdata[CTRL_TRIP];
  assign res_finish = wr & reg_hit(paddr, OFS_RESULT) & pwdata[RES_FINISH];
  assign res_error = wr & reg_hit(paddr, OFS_RESULT) & pwdata[RES_ERROR];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= CTRL_RST;
    else if (wr && reg_hit(paddr, OFS_CTRL))
      ctrl_ff <= {pwdata[CTRL_LINK], pwdata[CTRL_WARN], 1'b0};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_class_ff <= 2'h0;
    else if (wr && reg_hit(paddr, OFS_CMD))
      cmd_class_ff <= pwdata[CMD_CLASS_LSB +: 2];
  end

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DONE,
    ST_ERR
  } frio_st_t;

  frio_st_t st_ff;
  frio_st_t nxt_st;
  frio_cmd_class_t run_class_ff;
  logic exec_lvl;
  logic exec_rise;
  assign exec_lvl = req_s[CTL_EXEC];
  assign exec_rise = req_rise[CTL_EXEC];

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:
        if (exec_rise)
          nxt_st = ST_RUN;
      ST_RUN:
        if (res_error)
          nxt_st = ST_ERR;
        else if (res_finish)
          nxt_st = ST_DONE;
      ST_DONE, ST_ERR:
        if (!exec_lvl)
          nxt_st = ST_IDLE;
      default:
        nxt_st = ST_IDLE;
    endcase
    // Execute dropped mid-run: abandon without a result
    if (st_ff == ST_RUN && !exec_lvl && !res_error && !res_finish)
      nxt_st = ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= ST_IDLE;
    else
      st_ff <= nxt_st;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_class_ff <= CMD_PARAM;
    else if (st_ff == ST_IDLE && exec_rise)
      run_class_ff <= frio_cmd_class_t'(cmd_class_ff);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_launch <= 1'b0;
    else
      cmd_launch <= (st_ff == ST_IDLE) && exec_rise;
  end

  // ----------------------------------------------------------------
  // Monitor failures, per channel, set by firmware
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < MON_CH; i++)
    begin : g_mon
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mon_fail_ff[i] <= 1'b0;
        else if (wr && reg_hit(paddr, OFS_MON_FAIL) && pwdata[i])
          mon_fail_ff[i] <= 1'b1;
        else if (!req_s[CTL_MON_LSB + i])
          mon_fail_ff[i] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Alarm
  // ----------------------------------------------------------------
  logic alarm_flag_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alarm_flag_ff <= 1'b0;
    else if (trip)
      alarm_flag_ff <= 1'b1;
    else if (req_fall[CTL_ALM_CLR])
      alarm_flag_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic [15:0] nxt_sts;
  always_comb
  begin
    nxt_sts = STS_RST;
    nxt_sts[CTL_MON_LSB +: MON_CH] = req_s[CTL_MON_LSB +: MON_CH] & ~mon_fail_ff;
    nxt_sts[STS_WARN] = ctrl_ff[CTRL_WARN];
    nxt_sts[STS_ALARM] = alarm_flag_ff;
    nxt_sts[STS_LINK] = ctrl_ff[CTRL_LINK];
    nxt_sts[STS_DONE] = (st_ff == ST_DONE);
    nxt_sts[STS_REG_ERR] = (st_ff == ST_ERR) | (|mon_fail_ff);
    nxt_sts[STS_BUSY] = (st_ff == ST_RUN) &&
                        (run_class_ff == CMD_PARAM || run_class_ff == CMD_MAINT);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      device_to_master_bits <= STS_RST;
    else
      device_to_master_bits <= nxt_sts;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] ev;
  assign ev[EV_DONE] = (st_ff == ST_RUN) && (nxt_st == ST_DONE);
  assign ev[EV_ERR] = (st_ff == ST_RUN) && (nxt_st == ST_ERR);
  assign ev[EV_ALARM] = trip;
  assign ev[EV_LAUNCH] = (st_ff == ST_IDLE) && exec_rise;

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_sts_ff <= IRQ_RST;
    else if (wr && reg_hit(paddr, OFS_IRQ_CLR))
      irq_sts_ff <= (irq_sts_ff & ~pwdata[IRQ_W-1:0]) | ev;
    else
      irq_sts_ff <= irq_sts_ff | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_en_ff <= IRQ_RST;
    else if (wr && reg_hit(paddr, OFS_IRQ_EN))
      irq_en_ff <= pwdata[IRQ_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_sts_ff & irq_en_ff);
  end

  // ----------------------------------------------------------------
  // APB read path; answers in the access cycle, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rmux = {29'h0, ctrl_ff};
      OFS_STATUS: rmux = {16'h0, device_to_master_bits};
      OFS_CMD: rmux = {30'h0, cmd_class_ff};
      OFS_RESULT: rmux = {30'h0, st_ff};
      OFS_MON_FAIL: rmux = {26'h0, mon_fail_ff};
      OFS_IRQ_STS: rmux = {28'h0, irq_sts_ff};
      OFS_IRQ_EN: rmux = {28'h0, irq_en_ff};
      default: rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // Registered ready: setup cycle arms it, access completes next edge
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite)
        prdata <= rmux;
    end
  end

  logic unused;
  assign unused = rd;
endmodule
`default_nettype wire

// ### verification/frio_top_sva.sv
// Checker for the remote-I/O handshake: sees only the top module's ports.
// Assumes the two-edge status latency of the request sampler.
`timescale 1ns/1ps
`default_nettype none
module frio_top_sva
  import frio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] master_to_device_bits,
  input wire logic [15:0] device_to_master_bits,
  input wire logic cmd_launch,
  input wire logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------
  // Handshake properties
  // ----------------------------------------
  wire logic [15:0] b = master_to_device_bits;
  wire logic [15:0] d = device_to_master_bits;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // No APB access alongside, so a trip cannot beat the clear
  sequence clr_fall;
    b[CTL_ALM_CLR] ##1 !b[CTL_ALM_CLR] && !psel;
  endsequence
  a_launch_on_rise: assert property (cmd_launch |->
    $past(b[CTL_EXEC], 2) && !$past(b[CTL_EXEC], 3)) else $error("launch without rise");
  a_launch_one_pulse: assert property (cmd_launch |=> !cmd_launch)
    else $error("launch longer than a cycle");
  a_alarm_clear: assert property (clr_fall |-> ##3 !d[STS_ALARM])
    else $error("alarm not cleared");
  a_alarm_held: assert property ($fell(d[STS_ALARM]) |->
    $past(b[CTL_ALM_CLR], 4) && !$past(b[CTL_ALM_CLR], 3)) else $error("alarm dropped");
  a_unused_zero: assert property (d[11:9] == 3'h0 && !d[15])
    else $error("unassigned status bit set");
  a_monitor_req: assert property ((d[5:0] & ~$past(b[5:0], 2)) == 6'h00)
    else $error("monitor active without request");
  a_done_exec: assert property (d[STS_DONE] |-> $past(b[CTL_EXEC], 3))
    else $error("done without execute");
  a_busy_launch: assert property ($rose(d[STS_BUSY]) |-> $past(cmd_launch))
    else $error("busy without launch");
  a_busy_not_done: assert property (d[STS_BUSY] |-> !d[STS_DONE])
    else $error("busy and done together");
endmodule
bind frio_top frio_top_sva frio_top_sva_i (.pclk(pclk), .presetn(presetn),
  .master_to_device_bits(master_to_device_bits), .device_to_master_bits(device_to_master_bits),
  .cmd_launch(cmd_launch), .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### verification/frio_fbm.sv
// Fieldbus master model: drives the control word of the converter.
// Assumes the bench calls put for every bit change.
`timescale 1ns/1ps
`default_nettype none
module frio_fbm (
  input wire logic pclk,
  output logic [15:0] bits
);
  // ----------------------------------------
  // Request driver
  // ----------------------------------------
  initial bits = 16'h0000;
  // Held three edges so the two-stage sampler sees every change
  task put(input int i, input logic v);
    @(posedge pclk);
    bits[i] <= v;
    repeat (2) @(posedge pclk);
    #1;
  endtask
endmodule
`default_nettype wire

// ### verification/fieldbus_remote_io_handshake_bench.sv
// Self-checking bench of the handshake block with a fieldbus master model.
// Assumes frio_top, frio_fbm and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_remote_io_handshake_bench;
  import frio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  wire logic [31:0] prdata;
  wire logic [15:0] m2d, d2m;
  wire logic cmd_launch, irq, pready, pslverr;
  int errors, num_checks;
  frio_top frio_top_i (.pclk(pclk), .presetn(presetn), .master_to_device_bits(m2d),
    .device_to_master_bits(d2m), .cmd_launch(cmd_launch), .irq(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  frio_fbm frio_fbm_i (.pclk(pclk), .bits(m2d));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    #1;
    n = 0;
    // Answer is looked at once settled; the following edge completes the access
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (n >= 20)
    begin
      errors++;
      test_done;
    end
    rd = prdata;
    serr = pslverr;
    @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
    #1;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_mon;
    for (int i = 0; i < MON_CH; i++)
    begin
      frio_fbm_i.put(i, 1'b1);
      chk(d2m[5:0], (1 << (i + 1)) - 1);
    end
    apb(1'b1, OFS_MON_FAIL, 32'h4);
    wt(2);
    chk(d2m[5:0], 6'h3b);
    chk(d2m[STS_REG_ERR], 1'b1);
    frio_fbm_i.put(2, 1'b0);
    wt(1);
    chk(d2m[STS_REG_ERR], 1'b0);
    for (int i = 0; i < MON_CH; i++)
      frio_fbm_i.put(i, 1'b0);
    chk(d2m[5:0], 6'h00);
    $display("monitor test done");
  endtask
  task t_cmd;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, OFS_CMD, 32'(k % 3));
      frio_fbm_i.put(CTL_EXEC, 1'b1);
      chk(cmd_launch, 1'b1);
      wt(1);
      chk(d2m[STS_BUSY], (k % 3) != 2);
      wt(2);
      chk(cmd_launch, 1'b0);
      apb(1'b1, OFS_RESULT, (k == 3) ? 32'h2 : 32'h1);
      wt(2);
      chk(d2m[14:12], (k == 3) ? 3'h2 : 3'h1);
      frio_fbm_i.put(CTL_EXEC, 1'b0);
      wt(1);
      chk(d2m[14:12], 3'h0);
    end
    $display("command test done");
  endtask
  task t_alarm;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, OFS_IRQ_EN, (k == 0) ? 32'h4 : 32'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      wt(2);
      chk(d2m[STS_ALARM], 1'b1);
      chk(irq, k == 0);
      frio_fbm_i.put(CTL_ALM_CLR, 1'b1);
      chk(d2m[STS_ALARM], 1'b1);
      frio_fbm_i.put(CTL_ALM_CLR, 1'b0);
      wt(1);
      chk(d2m[STS_ALARM], 1'b0);
      apb(1'b0, OFS_IRQ_STS, 32'h0);
      chk(rd[EV_ALARM], 1'b1);
      apb(1'b1, OFS_IRQ_CLR, 32'hf);
      wt(2);
      chk(irq, 1'b0);
    end
    $display("alarm test done");
  endtask
  task t_misc;
    apb(1'b1, OFS_CTRL, 32'h6);
    wt(2);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[15:0], 16'h0140);
    chk(d2m, 16'h0140);
    apb(1'b0, 8'h40, 32'h0);
    chk(serr, 1'b1);
    chk(rd, 32'h0);
    $display("status test done");
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; errors = 0; num_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    chk(d2m, STS_RST);
    chk(irq, 1'b0);
    t_mon;
    t_cmd;
    t_alarm;
    t_misc;
    test_done;
  end
endmodule
`default_nettype wire
